// file: bench/prog_file_model.sv
// Behavioural program memory and file register space facing the instruction core.
`timescale 1ns/10ps
module prog_file_model #(
    parameter int PC_W = 11
) (
    input  wire logic [PC_W-1:0] prog_addr_r,
    input  wire logic            clk_sys,
    input  wire logic [6:0]      file_addr_r,
    input  wire logic            file_rd_r,
    input  wire logic            file_wr_r,
    input  wire logic [7:0]      file_wdata_r,
    output logic      [13:0]     prog_data,
    output logic      [7:0]      file_rdata
);
    logic [13:0] rom [0:(1<<PC_W)-1];
    logic [7:0]  ram [0:127];
    int          rd_cnt [0:127];
    int          cyc = 0;
    int          wr_cyc [$];
    logic [6:0]  wr_adr [$];

    // ==========================================================
    // Read paths
    assign prog_data = rom[prog_addr_r];
    // Outside the read strobe the bus shows the inverse, so a late sample cannot pass by luck.
    assign file_rdata = file_rd_r ? ram[file_addr_r] : ~ram[file_addr_r];

    // ==========================================================
    // Strobe log
    always @(posedge clk_sys) begin
        cyc = cyc + 1;
        if (file_rd_r === 1'b1) begin
            rd_cnt[file_addr_r] = rd_cnt[file_addr_r] + 1;
        end
        if (file_wr_r === 1'b1) begin
            ram[file_addr_r] = file_wdata_r;
            wr_cyc.push_back(cyc);
            wr_adr.push_back(file_addr_r);
        end
    end
endmodule

// file: bench/tb.sv
// Self-checking testbench for the instruction execution core.
`timescale 1ns/10ps
module tb;
    import core_pkg::*;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic        clk_en = 1'b1;
    logic [7:0]  pin_levels = 8'h00;
    logic [13:0] prog_data;
    logic [7:0]  file_rdata;
    logic [10:0] prog_addr_r;
    logic [6:0]  file_addr_r;
    logic        file_rd_r;
    logic        file_wr_r;
    logic [7:0]  file_wdata_r;
    logic [7:0]  w_r;
    logic        carry_r;
    logic        half_carry_flag_r;
    logic        zero_r;
    logic        timeout_flag_r;
    logic        powerdown_flag_r;
    logic        wdt_clear_r;
    logic        standby_r;
    int          err_total = 0;
    int          tests_run = 0;
    int          n_wdt, n_stby, n_fall, n_rise;

    always #5 clk_sys = ~clk_sys;

    insn_core u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .prog_data(prog_data),
        .file_rdata(file_rdata), .pin_levels(pin_levels), .prog_addr_r(prog_addr_r),
        .file_addr_r(file_addr_r), .file_rd_r(file_rd_r), .file_wr_r(file_wr_r),
        .file_wdata_r(file_wdata_r), .w_r(w_r), .carry_r(carry_r),
        .half_carry_flag_r(half_carry_flag_r), .zero_r(zero_r), .timeout_flag_r(timeout_flag_r),
        .powerdown_flag_r(powerdown_flag_r), .wdt_clear_r(wdt_clear_r), .standby_r(standby_r));

    prog_file_model u_mem (.prog_addr_r(prog_addr_r), .clk_sys(clk_sys), .file_addr_r(file_addr_r),
        .file_rd_r(file_rd_r), .file_wr_r(file_wr_r), .file_wdata_r(file_wdata_r),
        .prog_data(prog_data), .file_rdata(file_rdata));

    // ==========================================================
    // Status pulse and flag edge monitor
    always @(posedge clk_sys) begin
        if (rst_n) begin
            n_wdt  = n_wdt + (wdt_clear_r === 1'b1);
            n_stby = n_stby + (standby_r === 1'b1);
            n_fall = n_fall + $fell(powerdown_flag_r);
            n_rise = n_rise + $rose(powerdown_flag_r);
        end
    end

    // ==========================================================
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Holds reset and wipes memory; program words are loaded before release.
    task automatic prep();
        @(posedge clk_sys);
        #1 rst_n = 1'b0;
        for (int i = 0; i < 2048; i++) u_mem.rom[i] = 14'h0000;
        for (int i = 0; i < 128; i++) begin
            u_mem.ram[i] = 8'h00;
            u_mem.rd_cnt[i] = 0;
        end
        u_mem.wr_cyc.delete();
        u_mem.wr_adr.delete();
        n_wdt = 0;
        n_stby = 0;
        n_fall = 0;
        n_rise = 0;
    endtask

    task automatic go(input int n);
        repeat (8) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_byte();
        prep();
        u_mem.ram[7'h20] = 8'h15;
        u_mem.rom[0] = 14'h3003;
        u_mem.rom[1] = 14'h0720;
        u_mem.rom[2] = 14'h07A0;
        u_mem.rom[3] = 14'h00FF;
        u_mem.rom[4] = 14'h2804;
        go(60);
        check(w_r, 8'h18);
        check(u_mem.ram[7'h20], 8'h2D);
        check(u_mem.ram[7'h7F], 8'h18);
    endtask

    task automatic t_bits();
        prep();
        u_mem.ram[7'h30] = 8'hA5;
        u_mem.rom[0] = 14'h1730;
        u_mem.rom[1] = 14'h1030;
        u_mem.rom[2] = 14'h1830;
        u_mem.rom[3] = 14'h3011;
        u_mem.rom[4] = 14'h1FB0;
        u_mem.rom[5] = 14'h3022;
        u_mem.rom[6] = 14'h1BB0;
        u_mem.rom[7] = 14'h3044;
        u_mem.rom[8] = 14'h1CB0;
        // The don't-care bit of the add-literal code is set here on purpose.
        u_mem.rom[9] = 14'h3F01;
        u_mem.rom[10] = 14'h280A;
        go(120);
        check(u_mem.ram[7'h30], 8'hE4);
        check(w_r, 8'h45);
        check(half_carry_flag_r, 1'b0);
    endtask

    task automatic t_timing();
        prep();
        u_mem.ram[7'h42] = 8'h5A;
        u_mem.ram[7'h43] = 8'h77;
        u_mem.rom[0] = 14'h3001;
        u_mem.rom[1] = 14'h00C0;
        u_mem.rom[2] = 14'h00C1;
        u_mem.rom[3] = 14'h18C0;
        u_mem.rom[4] = 14'h00C2;
        u_mem.rom[5] = 14'h01C3;
        u_mem.rom[6] = 14'h2808;
        u_mem.rom[7] = 14'h00C5;
        u_mem.rom[8] = 14'h00C4;
        u_mem.rom[9] = 14'h2809;
        go(100);
        check(u_mem.wr_adr.size(), 4);
        if (u_mem.wr_adr.size() == 4) begin
            check(u_mem.wr_cyc[1] - u_mem.wr_cyc[0], 4);
            check(u_mem.wr_cyc[2] - u_mem.wr_cyc[1], 12);
            check(u_mem.wr_cyc[3] - u_mem.wr_cyc[2], 12);
            check(u_mem.wr_adr[3], 7'h44);
        end
        check(u_mem.ram[7'h43], 8'h00);
        check(u_mem.rd_cnt[7'h43], 1);
        check(zero_r, 1'b1);
        check(u_mem.rd_cnt[7'h42], 0);
        check(u_mem.rd_cnt[7'h45], 0);
        check(u_mem.ram[7'h42], 8'h5A);
    endtask

    task automatic t_port();
        prep();
        pin_levels = 8'h3C;
        u_mem.ram[7'h05] = 8'hFF;
        u_mem.rom[0] = 14'h0805;
        u_mem.rom[1] = 14'h0885;
        u_mem.rom[2] = 14'h2802;
        go(40);
        check(w_r, 8'h3C);
        check(u_mem.ram[7'h05], 8'h3C);
    endtask

    task automatic t_status();
        prep();
        u_mem.rom[0] = STANDBY_CODE;
        u_mem.rom[1] = WDT_CLR_CODE;
        u_mem.rom[2] = 14'h2802;
        go(1);
        check({timeout_flag_r, powerdown_flag_r}, 2'h3);
        repeat (40) @(posedge clk_sys);
        #1;
        check(n_stby, 1);
        check(n_fall, 1);
        check(n_wdt, 1);
        check(n_rise, 1);
        check({timeout_flag_r, powerdown_flag_r}, 2'h3);
    endtask

    task automatic t_flow();
        prep();
        u_mem.ram[7'h21] = 8'h01;
        u_mem.ram[7'h22] = 8'h18;
        u_mem.rom[0] = 14'h30F0;
        u_mem.rom[1] = 14'h0722;
        u_mem.rom[2] = 14'h0DA2;
        u_mem.rom[3] = 14'h0BA1;
        u_mem.rom[4] = 14'h30AA;
        u_mem.rom[5] = 14'h2010;
        u_mem.rom[6] = 14'h00A3;
        u_mem.rom[7] = 14'h2807;
        u_mem.rom[16] = 14'h3C10;
        u_mem.rom[17] = 14'h2020;
        u_mem.rom[18] = RETURN_CODE;
        u_mem.rom[32] = 14'h3433;
        go(16);
        check(prog_addr_r, 11'h004);
        // The stall starts at a cycle boundary; clock enable low must freeze the phase count too.
        clk_en = 1'b0;
        repeat (8) @(posedge clk_sys);
        #1 clk_en = 1'b1;
        check(prog_addr_r, 11'h004);
        check(w_r, 8'h08);
        repeat (70) @(posedge clk_sys);
        #1;
        check(u_mem.ram[7'h22], 8'h31);
        check(u_mem.ram[7'h21], 8'h00);
        check(carry_r, 1'b1);
        check(w_r, 8'h33);
        check(u_mem.ram[7'h23], 8'h33);
    endtask

    // ==========================================================
    // Verdict
    task automatic end_of_test();
        if (err_total == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // A full run needs about 510 clocks; twenty times that marks a hang.
    initial begin
        #100000;
        err_total++;
        end_of_test();
    end

    initial begin
        t_byte();
        t_bits();
        t_timing();
        t_port();
        t_status();
        t_flow();
        end_of_test();
    end
endmodule

// file: rtl/core_pkg.sv
// Shared constants, opcode enumeration and arithmetic helper for the instruction core.
package core_pkg;
    // ==========================================================
    // Widths and field positions
    localparam int INSN_W = 14;
    localparam int F_MSB  = 6;
    localparam int D_BIT  = 7;
    localparam int B_LSB  = 7;
    localparam int B_MSB  = 9;
    localparam int K8_MSB = 7;
    localparam int K11_MSB = 10;

    // ==========================================================
    // Instruction cycle phases, four oscillator periods each cycle
    localparam logic [1:0] Q_RD  = 2'h0;
    localparam logic [1:0] Q_CAP = 2'h1;
    localparam logic [1:0] Q_WR  = 2'h2;
    localparam logic [1:0] Q_END = 2'h3;

    // ==========================================================
    // Fixed whole-word encodings
    localparam logic [13:0] WDT_CLR_CODE = 14'h0064;
    localparam logic [13:0] STANDBY_CODE = 14'h0063;
    localparam logic [13:0] RETURN_CODE  = 14'h0008;
    localparam logic [13:0] RETINT_CODE  = 14'h0009;

    // ==========================================================
    // Reset values
    localparam logic [7:0] W_RST    = 8'h00;
    localparam logic       FLAG_RST = 1'b0;
    localparam logic       TMO_RST  = 1'b1;
    localparam logic       PWD_RST  = 1'b1;

    typedef enum logic [5:0] {
        OP_NOP, OP_MOVWF, OP_CLR, OP_SUB, OP_DEC, OP_IOR, OP_AND, OP_XOR, OP_ADD,
        OP_MOV, OP_COM, OP_INC, OP_DECSZ, OP_RRF, OP_RLF, OP_SWAP, OP_INCSZ,
        OP_BIT_CLR, OP_BIT_SET, OP_SKIP_CLR, OP_SKIP_SET,
        OP_MOVLW, OP_RETLW, OP_IORLW, OP_ANDLW, OP_XORLW, OP_SUBLW, OP_ADDLW,
        OP_CALL, OP_GOTO, OP_RETURN, OP_RETINT, OP_STANDBY, OP_WDT_CLR
    } op_e;

    // Returns {carry, half carry, sum}.
    function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b, input logic ci);
        logic [8:0] s;
        logic [4:0] h;
        s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        return {s[8], h[4], s[7:0]};
    endfunction
endpackage

// file: rtl/dec_if.sv
// Carrier between the decoder and the execution core.
`timescale 1ns/10ps
interface dec_if;
    import core_pkg::*;
    logic [INSN_W-1:0] ir;
    op_e               op;
    logic [6:0]        f;
    logic              d;
    logic [2:0]        b;
    logic [7:0]        k8;
    logic [10:0]       k11;
    logic              uses_file;
    modport dec (input ir, output op, f, d, b, k8, k11, uses_file);
    modport exe (output ir, input op, f, d, b, k8, k11, uses_file);
endinterface

// file: rtl/insn_core.sv
// Instruction execution core: cycle timing, operand access, result write-back and flow control.
// Behaviour
// - Each instruction is one 14-bit word: opcode plus operand fields.
// - Byte ops store result in the accumulator when d is 0, file when 1.
// - The file address field selects one register from 0x00 to 0x7F.
// - Bit ops change only the selected bit of the addressed 8-bit register.
// - Literal field is an 8-bit or 11-bit constant depending on opcode.
// - One instruction cycle lasts exactly four oscillator periods.
// - One cycle per instruction; taken skips and jumps add a no-operation cycle.
// - Any op naming a file register reads it; only bit clear/set and byte ops with d of 1 store it back.
// - Don't-care opcode bits never change decoding; tools should emit zeros.
// - Reading the port register takes pin levels, not the output latch.
// - Bit ops are 01, then clear/set/skip-clear/skip-set, bit select, file address.
// - Watchdog clear op is 0x0064, one cycle, sets timeout and powerdown flags.
// - Standby op is 0x0063, one cycle, sets timeout flag, clears powerdown flag.
`timescale 1ns/10ps
module insn_core
    import core_pkg::*;
#(
    parameter int         PC_W     = 11,
    parameter int         STACK_D  = 8,
    parameter logic [6:0] PORT_ADDR = 7'h05
) (
    input  wire logic            clk_sys,
    input  wire logic            rst_n,
    input  wire logic            clk_en,
    input  wire logic [13:0]     prog_data,
    input  wire logic [7:0]      file_rdata,
    input  wire logic [7:0]      pin_levels,
    output logic      [PC_W-1:0] prog_addr_r,
    output logic      [6:0]      file_addr_r,
    output logic                 file_rd_r,
    output logic                 file_wr_r,
    output logic      [7:0]      file_wdata_r,
    output logic      [7:0]      w_r,
    output logic                 carry_r,
    output logic                 half_carry_flag_r,
    output logic                 zero_r,
    output logic                 timeout_flag_r,
    output logic                 powerdown_flag_r,
    output logic                 wdt_clear_r,
    output logic                 standby_r
);
    localparam int SP_W = $clog2(STACK_D);

    dec_if dif ();
    insn_decode u_dec (
        .ifc (dif)
    );

    logic [1:0]      q_r;
    logic            flush_r;
    logic [13:0]     ir_r;
    logic [7:0]      opnd_r;
    logic [PC_W-1:0] stack_r [STACK_D];
    logic [SP_W-1:0] sp_r;
    logic [7:0]      res;
    logic [7:0]      mask;
    logic [9:0]      sum;
    logic            exec;
    logic            wr_w;
    logic            wr_f;
    logic            byte_dst;
    logic            z_aff;
    logic            c_nxt;
    logic            h_nxt;
    logic            skip;
    logic            jump;
    logic            push;
    logic            pop;
    logic [PC_W-1:0] tgt;

    assign dif.ir = ir_r;
    assign exec   = !flush_r;
    assign mask   = 8'(8'h01 << dif.b);

    // ==========================================================
    // Phase counter
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            q_r <= Q_RD;
        end else if (clk_en) begin
            q_r <= q_r + 2'h1;
        end
    end

    // ==========================================================
    // Result logic
    always_comb begin
        res = opnd_r;
        sum = add8(w_r, opnd_r, 1'b0);
        wr_w = 1'b0;
        wr_f = 1'b0;
        byte_dst = 1'b1;
        z_aff = 1'b1;
        c_nxt = carry_r;
        h_nxt = half_carry_flag_r;
        skip = 1'b0;
        jump = 1'b0;
        push = 1'b0;
        pop = 1'b0;
        tgt = PC_W'(dif.k11);
        case (dif.op)
            OP_MOVWF: begin res = w_r; z_aff = 1'b0; end
            OP_CLR:   res = 8'h00;
            OP_SUB: begin sum = add8(opnd_r, ~w_r, 1'b1); res = sum[7:0]; {c_nxt, h_nxt} = sum[9:8]; end
            OP_DEC:   res = opnd_r - 8'h01;
            OP_IOR:   res = opnd_r | w_r;
            OP_AND:   res = opnd_r & w_r;
            OP_XOR:   res = opnd_r ^ w_r;
            OP_ADD: begin res = sum[7:0]; {c_nxt, h_nxt} = sum[9:8]; end
            OP_MOV:   res = opnd_r;
            OP_COM:   res = ~opnd_r;
            OP_INC:   res = opnd_r + 8'h01;
            OP_DECSZ: begin res = opnd_r - 8'h01; z_aff = 1'b0; skip = (res == 8'h00); end
            OP_INCSZ: begin res = opnd_r + 8'h01; z_aff = 1'b0; skip = (res == 8'h00); end
            OP_RRF: begin res = {carry_r, opnd_r[7:1]}; c_nxt = opnd_r[0]; z_aff = 1'b0; end
            OP_RLF: begin res = {opnd_r[6:0], carry_r}; c_nxt = opnd_r[7]; z_aff = 1'b0; end
            OP_SWAP: begin res = {opnd_r[3:0], opnd_r[7:4]}; z_aff = 1'b0; end
            default: begin byte_dst = 1'b0; z_aff = 1'b0; end
        endcase
        if (byte_dst) begin
            wr_f = dif.d;
            wr_w = !dif.d;
        end
        case (dif.op)
            OP_BIT_CLR: begin res = opnd_r & ~mask; wr_f = 1'b1; end
            OP_BIT_SET: begin res = opnd_r | mask; wr_f = 1'b1; end
            OP_SKIP_CLR: skip = ((opnd_r & mask) == 8'h00);
            OP_SKIP_SET: skip = ((opnd_r & mask) != 8'h00);
            OP_MOVLW: begin res = dif.k8; wr_w = 1'b1; end
            OP_RETLW: begin res = dif.k8; wr_w = 1'b1; jump = 1'b1; pop = 1'b1; end
            OP_IORLW: begin res = dif.k8 | w_r; wr_w = 1'b1; z_aff = 1'b1; end
            OP_ANDLW: begin res = dif.k8 & w_r; wr_w = 1'b1; z_aff = 1'b1; end
            OP_XORLW: begin res = dif.k8 ^ w_r; wr_w = 1'b1; z_aff = 1'b1; end
            OP_SUBLW: begin
                sum = add8(dif.k8, ~w_r, 1'b1);
                res = sum[7:0];
                {c_nxt, h_nxt} = sum[9:8];
                wr_w = 1'b1;
                z_aff = 1'b1;
            end
            OP_ADDLW: begin
                sum = add8(w_r, dif.k8, 1'b0);
                res = sum[7:0];
                {c_nxt, h_nxt} = sum[9:8];
                wr_w = 1'b1;
                z_aff = 1'b1;
            end
            OP_CALL: begin jump = 1'b1; push = 1'b1; end
            OP_GOTO: jump = 1'b1;
            OP_RETURN, OP_RETINT: begin jump = 1'b1; pop = 1'b1; end
            default: ;
        endcase
        if (pop) begin
            tgt = stack_r[sp_r - SP_W'(1)];
        end
    end

    // ==========================================================
    // File register access: read in the second phase, write in the fourth.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            file_addr_r <= 7'h00;
            file_rd_r <= 1'b0;
            file_wr_r <= 1'b0;
            file_wdata_r <= 8'h00;
            opnd_r <= 8'h00;
        end else if (clk_en) begin
            case (q_r)
                Q_RD: begin
                    file_addr_r <= dif.f;
                    file_rd_r <= exec && dif.uses_file;
                end
                Q_CAP: begin
                    file_rd_r <= 1'b0;
                    opnd_r <= (file_addr_r == PORT_ADDR) ? pin_levels : file_rdata;
                end
                Q_WR: begin
                    file_wr_r <= exec && wr_f;
                    file_wdata_r <= res;
                end
                default: file_wr_r <= 1'b0;
            endcase
        end
    end

    // ==========================================================
    // Accumulator and arithmetic flags, committed at the end of the cycle.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            w_r <= W_RST;
            carry_r <= FLAG_RST;
            half_carry_flag_r <= FLAG_RST;
            zero_r <= FLAG_RST;
        end else if (clk_en && q_r == Q_END && exec) begin
            if (wr_w) begin
                w_r <= res;
            end
            carry_r <= c_nxt;
            half_carry_flag_r <= h_nxt;
            if (z_aff || dif.op == OP_CLR) begin
                zero_r <= (res == 8'h00);
            end
        end
    end

    // ==========================================================
    // Power status flags and their one-cycle request pulses.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            timeout_flag_r <= TMO_RST;
            powerdown_flag_r <= PWD_RST;
            wdt_clear_r <= 1'b0;
            standby_r <= 1'b0;
        end else if (clk_en) begin
            wdt_clear_r <= q_r == Q_END && exec && dif.op == OP_WDT_CLR;
            standby_r <= q_r == Q_END && exec && dif.op == OP_STANDBY;
            if (q_r == Q_END && exec && dif.op == OP_WDT_CLR) begin
                timeout_flag_r <= 1'b1;
                powerdown_flag_r <= 1'b1;
            end else if (q_r == Q_END && exec && dif.op == OP_STANDBY) begin
                timeout_flag_r <= 1'b1;
                powerdown_flag_r <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Fetch, flow control and return stack. The stack wraps silently when over-filled.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prog_addr_r <= '0;
            ir_r <= 14'h0000;
            flush_r <= 1'b1;
            sp_r <= '0;
        end else if (clk_en && q_r == Q_END) begin
            ir_r <= prog_data;
            if (exec && jump) begin
                prog_addr_r <= tgt;
                flush_r <= 1'b1;
            end else begin
                prog_addr_r <= prog_addr_r + PC_W'(1);
                flush_r <= exec && skip;
            end
            if (exec && push) begin
                sp_r <= sp_r + SP_W'(1);
            end else if (exec && pop) begin
                sp_r <= sp_r - SP_W'(1);
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (clk_en && q_r == Q_END && exec && push) begin
            stack_r[sp_r] <= prog_addr_r;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n || !clk_en);

    phase_four_a: assert property ((q_r == Q_RD) |=> q_r == Q_CAP ##1 q_r == Q_WR ##1 q_r == Q_END ##1 q_r == Q_RD)
        else $error("instruction cycle is not four periods");
    skip_extra_a: assert property ((q_r == Q_END && exec && (skip || jump)) |=> flush_r)
        else $error("taken skip or jump did not add a cycle");
    flush_quiet_a: assert property ((flush_r && q_r == Q_RD) |=> (!file_rd_r && !file_wr_r)[*4])
        else $error("discarded slot touched the file space");
    rmw_order_a: assert property ((q_r == Q_RD && exec && wr_f) |=> file_rd_r && q_r == Q_CAP)
        else $error("file write without prior read");
    acc_dest_a: assert property ((q_r == Q_END && exec && byte_dst && !dif.d) |=> w_r == $past(res))
        else $error("accumulator not written for d of 0");
    bit_only_a: assert property ((q_r == Q_END && file_wr_r && dif.ir[13:12] == 2'b01)
        |-> ((file_wdata_r ^ opnd_r) & ~mask) == 8'h00)
        else $error("bit op changed other bits");
    port_pins_a: assert property ((q_r == Q_CAP && file_addr_r == PORT_ADDR) |=> opnd_r == $past(pin_levels))
        else $error("port read did not use pin levels");
    goto_lit_a: assert property ((q_r == Q_END && exec && dif.op == OP_GOTO) |=> prog_addr_r == $past(tgt))
        else $error("jump target not taken from literal");
    wdt_flags_a: assert property ((q_r == Q_END && exec && dif.op == OP_WDT_CLR)
        |=> wdt_clear_r && timeout_flag_r && powerdown_flag_r ##1 !wdt_clear_r)
        else $error("watchdog clear flags wrong");
    standby_flags_a: assert property ((q_r == Q_END && exec && dif.op == OP_STANDBY)
        |=> standby_r && timeout_flag_r && !powerdown_flag_r ##1 !standby_r)
        else $error("standby flags wrong");
    bit_decode_a: assert property ((ir_r[13:10] == 4'b0110) |-> dif.op == OP_SKIP_CLR)
        else $error("bit op field decoded wrong");
endmodule

// file: rtl/insn_decode.sv
// Opcode and operand field decoder for the 14-bit instruction word.
`timescale 1ns/10ps
module insn_decode
    import core_pkg::*;
(
    dec_if.dec ifc
);
    // ==========================================================
    // Operand fields
    assign ifc.f   = ifc.ir[F_MSB:0];
    assign ifc.d   = ifc.ir[D_BIT];
    assign ifc.b   = ifc.ir[B_MSB:B_LSB];
    assign ifc.k8  = ifc.ir[K8_MSB:0];
    assign ifc.k11 = ifc.ir[K11_MSB:0];

    // ==========================================================
    // Opcode; unlisted codes of the control space fall back to no operation.
    always_comb begin
        ifc.op = OP_NOP;
        ifc.uses_file = 1'b0;
        casez (ifc.ir)
            WDT_CLR_CODE:          ifc.op = OP_WDT_CLR;
            STANDBY_CODE:          ifc.op = OP_STANDBY;
            RETURN_CODE:           ifc.op = OP_RETURN;
            RETINT_CODE:           ifc.op = OP_RETINT;
            14'b00_0000_0???_????: ifc.op = OP_NOP;
            14'b00_0000_1???_????: ifc.op = OP_MOVWF;
            14'b00_0001_????_????: ifc.op = OP_CLR;
            14'b00_0010_????_????: ifc.op = OP_SUB;
            14'b00_0011_????_????: ifc.op = OP_DEC;
            14'b00_0100_????_????: ifc.op = OP_IOR;
            14'b00_0101_????_????: ifc.op = OP_AND;
            14'b00_0110_????_????: ifc.op = OP_XOR;
            14'b00_0111_????_????: ifc.op = OP_ADD;
            14'b00_1000_????_????: ifc.op = OP_MOV;
            14'b00_1001_????_????: ifc.op = OP_COM;
            14'b00_1010_????_????: ifc.op = OP_INC;
            14'b00_1011_????_????: ifc.op = OP_DECSZ;
            14'b00_1100_????_????: ifc.op = OP_RRF;
            14'b00_1101_????_????: ifc.op = OP_RLF;
            14'b00_1110_????_????: ifc.op = OP_SWAP;
            14'b00_1111_????_????: ifc.op = OP_INCSZ;
            14'b01_00??_????_????: ifc.op = OP_BIT_CLR;
            14'b01_01??_????_????: ifc.op = OP_BIT_SET;
            14'b01_10??_????_????: ifc.op = OP_SKIP_CLR;
            14'b01_11??_????_????: ifc.op = OP_SKIP_SET;
            14'b10_0???_????_????: ifc.op = OP_CALL;
            14'b10_1???_????_????: ifc.op = OP_GOTO;
            14'b11_00??_????_????: ifc.op = OP_MOVLW;
            14'b11_01??_????_????: ifc.op = OP_RETLW;
            14'b11_1000_????_????: ifc.op = OP_IORLW;
            14'b11_1001_????_????: ifc.op = OP_ANDLW;
            14'b11_1010_????_????: ifc.op = OP_XORLW;
            14'b11_110?_????_????: ifc.op = OP_SUBLW;
            14'b11_111?_????_????: ifc.op = OP_ADDLW;
            default:               ifc.op = OP_NOP;
        endcase
        // Every op that names a file register reads it, including pure writes.
        if (ifc.ir[13:12] == 2'b01) begin
            ifc.uses_file = 1'b1;
        end else if (ifc.ir[13:12] == 2'b00) begin
            ifc.uses_file = (ifc.ir[11:8] != 4'h0 && ifc.ir[11:8] != 4'h1) || ifc.ir[D_BIT];
        end
    end
endmodule
